// file: sfic_pkg.sv
// =====================================================================
// Shared constants for the serial FIFO and interrupt control block.
// =====================================================================
package sfic_pkg;

  // Data path and FIFO shape.
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;

  // Register addresses on the 3-bit channel address.
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER  = 3'h1;
  localparam logic [2:0] ADDR_FIFO = 3'h2;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  localparam logic [2:0] ADDR_MSR  = 3'h6;

  // Field positions of the FIFO control word.
  localparam int FCR_EN      = 0;
  localparam int FCR_RXCLR   = 1;
  localparam int FCR_TXCLR   = 2;
  localparam int FCR_DMA     = 3;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;

  // Field positions of the interrupt enable mask.
  localparam int IER_RDA  = 0;
  localparam int IER_TX_HOLDING_EMPTY = 1;
  localparam int IER_LS   = 2;
  localparam int IER_MS   = 3;

  // Field positions inside the line status word.
  localparam int LSR_DR   = 0;
  localparam int LSR_TX_HOLDING_EMPTY = 5;

  // Reset values.
  localparam logic [3:0] IER_RESET  = 4'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;

  // Interrupt identification codes, bits 3:0, and the FIFO-on value of bits 7:6.
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LS   = 4'h6;
  localparam logic [3:0] IIR_RDA  = 4'h4;
  localparam logic [3:0] IIR_TMO  = 4'hc;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [3:0] IIR_MS   = 4'h0;
  localparam logic [1:0] IIR_FIFO_ON = 2'h3;

  // Receive trigger levels in bytes.
  localparam logic [CNT_W-1:0] TRIG_LVL0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL3 = 5'h0e;

  // Character timing, counted in receive baud clock ticks.
  localparam int TMO_W              = 10;
  localparam int BAUD_TICKS_PER_BIT = 16;
  localparam int TIMEOUT_CHARS      = 4;

  // Transmit empty indication states.
  typedef enum logic [2:0] {
    TX_EMPTY = 3'b001,
    TX_BUSY  = 3'b010,
    TX_DELAY = 3'b100
  } sfic_txst_t;

endpackage

// file: sfic_fifo_if.sv
`timescale 1ns/1ps
// =====================================================================
// Handshake bundle between the control logic and one FIFO.
// =====================================================================
interface sfic_fifo_if #(
  parameter int WIDTH = 8,
  parameter int CNT_W = 5
);
  logic             inValid;
  logic             inReady;
  logic [WIDTH-1:0] inData;
  logic             outValid;
  logic             outReady;
  logic [WIDTH-1:0] outData;
  logic [CNT_W-1:0] count;
  logic             clear;
  logic             single;

  modport store (input inValid, inData, outReady, clear, single,
                 output inReady, outValid, outData, count);
  modport user  (output inValid, inData, outReady, clear, single,
                 input inReady, outValid, outData, count);
endinterface

// file: sfic_fifo.sv
`timescale 1ns/1ps
// =====================================================================
// Small FIFO with registered head word and a one-entry mode.
// =====================================================================
module sfic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Data path
  sfic_fifo_if.store f
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [CNT_W-1:0] count;
  logic             headValid;
  logic [WIDTH-1:0] headWord;

  // In one-entry mode a single word fills the store.
  wire              full       = f.single ? (count != '0) : (count == CNT_W'(DEPTH));
  wire              push       = f.inValid && !full && !f.clear;
  wire              pop        = headValid && f.outReady && !f.clear;
  wire [CNT_W-1:0]  next_count = count + CNT_W'(push) - CNT_W'(pop);

  // The head register lags a pointer move by one cycle, so valid drops meanwhile.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || f.clear) begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      count     <= '0;
      headValid <= 1'b0;
      headWord  <= '0;
    end else begin
      wrPtr     <= push ? wrPtr + PTR_W'(1) : wrPtr;
      rdPtr     <= pop ? rdPtr + PTR_W'(1) : rdPtr;
      count     <= next_count;
      headValid <= (count != '0) && !pop;
      headWord  <= mem[rdPtr];
    end
  end

  // Storage array write port.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= f.inData;
    end
  end

  assign f.inReady  = !full;
  assign f.outValid = headValid;
  assign f.outData  = headWord;
  assign f.count    = count;

endmodule // sfic_fifo

// file: sfic_serial_fifo_irq.sv
`timescale 1ns/1ps
// =====================================================================
// FIFO control and interrupt identification of one serial channel.
// =====================================================================
module sfic_serial_fifo_irq
  import sfic_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Register bus
  input  wire logic              regRead,
  input  wire logic              regWrite,
  input  wire logic [2:0]        regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              divisorAccessBit,
  output logic      [DATA_W-1:0] regRdata,
  // Receive shift register side
  input  wire logic              rxCharValid,
  input  wire logic [DATA_W-1:0] rxCharData,
  output logic                   rxCharReady,
  // Transmit shift register side
  output logic                   txCharValid,
  output logic      [DATA_W-1:0] txCharData,
  input  wire logic              txCharTake,
  // Character timing
  input  wire logic              rxBaudClk,
  input  wire logic [3:0]        charBitTimes,
  // Status sources
  input  wire logic              lineStatusEvent,
  input  wire logic              modemStatusEvent,
  input  wire logic [DATA_W-1:0] lineStatusWord,
  input  wire logic [DATA_W-1:0] modemStatusWord,
  // Status and request outputs
  output logic                   rxDataReadyFlag,
  output logic                   txHoldingEmpty,
  output logic                   rxDmaRequest,
  output logic                   txDmaRequest,
  output logic                   channelAIrqOut
);

  // ===================================================================
  // Helper functions
  // ===================================================================

  // Maps the two trigger bits to a byte count.
  function automatic logic [CNT_W-1:0] trigLevel(input logic [1:0] code);
    case (code)
      2'h0:    trigLevel = TRIG_LVL0;
      2'h1:    trigLevel = TRIG_LVL1;
      2'h2:    trigLevel = TRIG_LVL2;
      default: trigLevel = TRIG_LVL3;
    endcase
  endfunction

  // ===================================================================
  // State
  // ===================================================================
  logic              fifoEnable;
  logic              dmaMode;
  logic [1:0]        trigCode;
  logic [3:0]        interrupt_enable_mask;
  logic              lsPending;
  logic              msPending;
  logic              tmoPending;
  logic              threPending;
  logic [TMO_W-1:0]  tmoCount;
  logic [TMO_W-1:0]  delayCount;
  sfic_txst_t        txState;
  sfic_txst_t        next_txState;
  logic              twoSeen;
  logic              immediateNext;
  logic [2:0]        baudSync;
  logic              baudLevel;
  logic [DATA_W-1:0] readValue;

  sfic_fifo_if #(.WIDTH(DATA_W), .CNT_W(CNT_W)) rxIf ();
  sfic_fifo_if #(.WIDTH(DATA_W), .CNT_W(CNT_W)) txIf ();

  // ===================================================================
  // Register decode
  // ===================================================================

  // Data and enable addresses belong to the divisor latches while access is set.
  wire wrData = regWrite && (regAddr == ADDR_DATA) && !divisorAccessBit;
  wire wrIer  = regWrite && (regAddr == ADDR_IER) && !divisorAccessBit;
  wire wrFcr  = regWrite && (regAddr == ADDR_FIFO);
  wire rdData = regRead && (regAddr == ADDR_DATA) && !divisorAccessBit;
  wire rdIir  = regRead && (regAddr == ADDR_FIFO);
  wire rdLsr  = regRead && (regAddr == ADDR_LSR);
  wire rdMsr  = regRead && (regAddr == ADDR_MSR);

  // FIFO clears: disable, mode change, or the per-direction clear bits.
  wire enChange = wrFcr && (regWdata[FCR_EN] != fifoEnable);
  wire rxClear  = wrFcr && (!regWdata[FCR_EN] || enChange || regWdata[FCR_RXCLR]);
  wire txClear  = wrFcr && (!regWdata[FCR_EN] || enChange || regWdata[FCR_TXCLR]);

  // ===================================================================
  // FIFOs
  // ===================================================================

  // Receive FIFO filled by the shift register, drained by host reads.
  assign rxIf.inValid  = rxCharValid;
  assign rxIf.inData   = rxCharData;
  assign rxIf.outReady = rdData;
  assign rxIf.clear    = rxClear;
  assign rxIf.single   = !fifoEnable;

  // Transmit FIFO filled by host writes, drained by the shift register.
  assign txIf.inValid  = wrData;
  assign txIf.inData   = regWdata;
  assign txIf.outReady = txCharTake;
  assign txIf.clear    = txClear;
  assign txIf.single   = !fifoEnable;

  sfic_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH), .CNT_W(CNT_W)) rxFifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (rxIf.store)
  );

  sfic_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH), .CNT_W(CNT_W)) txFifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .f       (txIf.store)
  );

  wire rxPush    = rxCharValid && rxIf.inReady && !rxClear;
  wire rxPop     = rdData && rxIf.outValid && !rxClear;
  wire rxAny     = rxIf.count != '0;
  wire rxReached = rxIf.count >= trigLevel(trigCode);
  wire txEmpty   = txIf.count == '0;

  // ===================================================================
  // Control word and enable mask
  // ===================================================================

  // Other control bits are only taken while the enable bit is written as one.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fifoEnable <= 1'b0;
      dmaMode    <= 1'b0;
      trigCode   <= TRIG_RESET;
      interrupt_enable_mask        <= IER_RESET;
    end else begin
      if (wrFcr) begin
        fifoEnable <= regWdata[FCR_EN];
        if (regWdata[FCR_EN]) begin
          dmaMode  <= regWdata[FCR_DMA];
          trigCode <= regWdata[FCR_TRIG_HI:FCR_TRIG_LO];
        end
      end
      if (wrIer) begin
        interrupt_enable_mask <= regWdata[3:0];
      end
    end
  end

  // ===================================================================
  // Receive baud clock synchroniser
  // ===================================================================

  // A rise to one counts once the second and third stages agree.
  wire baudTick = (baudSync[1] == baudSync[2]) && baudSync[2] && !baudLevel;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      baudSync  <= 3'h0;
      baudLevel <= 1'b0;
    end else begin
      baudSync  <= {baudSync[1:0], rxBaudClk};
      baudLevel <= (baudSync[1] == baudSync[2]) ? baudSync[2] : baudLevel;
    end
  end

  // ===================================================================
  // Character time-out
  // ===================================================================

  // Four character times, each charBitTimes bits of 16 baud ticks.
  wire [TMO_W-1:0] tmoLimit   = TMO_W'(TIMEOUT_CHARS * BAUD_TICKS_PER_BIT) *
                                TMO_W'(charBitTimes);
  wire             tmoRestart = !rxAny || rxPop || (rxPush && !tmoPending) || rxClear;
  wire             tmoHit     = fifoEnable && rxAny && !tmoRestart && (tmoCount == tmoLimit);
  wire             next_tmoPending = tmoHit ||
                                     (tmoPending && !rxPop && !rxClear && fifoEnable);

  // The timer saturates at its limit so a pending time-out stays until read.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tmoCount   <= '0;
      tmoPending <= 1'b0;
    end else begin
      tmoCount   <= tmoRestart ? '0 :
                    (baudTick && (tmoCount != tmoLimit)) ? tmoCount + TMO_W'(1) : tmoCount;
      tmoPending <= next_tmoPending;
    end
  end

  // ===================================================================
  // Transmit empty indication
  // ===================================================================

  // One character time less the final stop bit.
  wire [TMO_W-1:0] delayLimit = TMO_W'(BAUD_TICKS_PER_BIT) *
                                TMO_W'(charBitTimes - 4'h1);

  // Delay applies only in FIFO mode, without two bytes seen and no pending bypass.
  always_comb begin
    next_txState = txState;
    case (txState)
      TX_EMPTY: begin
        if (!txEmpty) begin
          next_txState = TX_BUSY;
        end
      end
      TX_BUSY: begin
        if (txEmpty) begin
          if (fifoEnable && !twoSeen && !immediateNext) begin
            next_txState = TX_DELAY;
          end else begin
            next_txState = TX_EMPTY;
          end
        end
      end
      TX_DELAY: begin
        if (!txEmpty) begin
          next_txState = TX_BUSY;
        end else if (delayCount == delayLimit || immediateNext) begin
          next_txState = TX_EMPTY;
        end
      end
      default: next_txState = TX_EMPTY;
    endcase
  end

  wire enterEmpty = (next_txState == TX_EMPTY) && (txState != TX_EMPTY);
  wire ierThreOn  = wrIer && regWdata[IER_TX_HOLDING_EMPTY] && !interrupt_enable_mask[IER_TX_HOLDING_EMPTY] && (txState == TX_EMPTY);

  // State, delay timer and the two-byte history since the last empty.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txState       <= TX_EMPTY;
      delayCount    <= '0;
      twoSeen       <= 1'b0;
      immediateNext <= 1'b0;
    end else begin
      txState       <= next_txState;
      delayCount    <= (txState != TX_DELAY) ? '0 :
                       baudTick ? delayCount + TMO_W'(1) : delayCount;
      twoSeen       <= enterEmpty ? 1'b0 : (twoSeen || (txIf.count >= CNT_W'(2)));
      immediateNext <= enChange || (immediateNext && !enterEmpty);
    end
  end

  // ===================================================================
  // Interrupt sources
  // ===================================================================

  // Sources identified by the current report, for the read-clear of holding empty.
  wire lsOn   = interrupt_enable_mask[IER_LS] && lsPending;
  wire rdaSrc = fifoEnable ? rxReached : rxAny;
  wire rdaOn  = interrupt_enable_mask[IER_RDA] && rdaSrc;
  wire tmoOn  = interrupt_enable_mask[IER_RDA] && tmoPending;
  wire threOn = interrupt_enable_mask[IER_TX_HOLDING_EMPTY] && threPending;
  wire msOn   = interrupt_enable_mask[IER_MS] && msPending;

  // Highest ranked enabled source wins the report.
  wire [3:0] iirCode = lsOn   ? IIR_LS   :
                       rdaOn  ? IIR_RDA  :
                       tmoOn  ? IIR_TMO  :
                       threOn ? IIR_TX_HOLDING_EMPTY :
                       msOn   ? IIR_MS   : IIR_NONE;
  wire [7:0] iirWord = {(fifoEnable ? IIR_FIFO_ON : 2'h0), 2'h0, iirCode};

  // Sticky pending flags; a set in the cycle of its clear wins.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lsPending   <= 1'b0;
      msPending   <= 1'b0;
      threPending <= 1'b0;
    end else begin
      lsPending   <= lineStatusEvent || (lsPending && !rdLsr);
      msPending   <= modemStatusEvent || (msPending && !rdMsr);
      threPending <= enterEmpty || ierThreOn ||
                     (threPending && !wrData && !(rdIir && iirCode == IIR_TX_HOLDING_EMPTY));
    end
  end

  // ===================================================================
  // Read data and outputs
  // ===================================================================

  // Read data selection; unmapped or divisor-owned addresses read zero.
  always_comb begin
    readValue = 8'h00;
    if (regAddr == ADDR_DATA && !divisorAccessBit) begin
      readValue = rxIf.outData;
    end else if (regAddr == ADDR_IER && !divisorAccessBit) begin
      readValue = {4'h0, interrupt_enable_mask};
    end else if (regAddr == ADDR_FIFO) begin
      readValue = iirWord;
    end else if (regAddr == ADDR_LSR) begin
      readValue                = lineStatusWord;
      readValue[LSR_DR]        = rxAny;
      readValue[LSR_TX_HOLDING_EMPTY]      = txState == TX_EMPTY;
    end else if (regAddr == ADDR_MSR) begin
      readValue = modemStatusWord;
    end
  end

  // Registered outputs; DMA mode 1 applies only with FIFOs enabled.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdata        <= 8'h00;
      rxCharReady     <= 1'b0;
      rxDataReadyFlag <= 1'b0;
      txHoldingEmpty  <= 1'b1;
      rxDmaRequest    <= 1'b0;
      txDmaRequest    <= 1'b0;
      channelAIrqOut  <= 1'b0;
    end else begin
      regRdata        <= regRead ? readValue : regRdata;
      rxCharReady     <= rxIf.inReady;
      rxDataReadyFlag <= rxAny;
      txHoldingEmpty  <= next_txState == TX_EMPTY;
      rxDmaRequest    <= (fifoEnable && dmaMode) ? (rxReached || tmoPending) : rxAny;
      txDmaRequest    <= (fifoEnable && dmaMode) ? txIf.inReady :
                         (next_txState == TX_EMPTY);
      channelAIrqOut  <= iirCode != IIR_NONE;
    end
  end

  assign txCharValid = txIf.outValid;
  assign txCharData  = txIf.outData;

endmodule // sfic_serial_fifo_irq

// file: sfic_serial_fifo_irq_sva.sv
`timescale 1ns/1ps
// =====================================================================
// Port checks of the serial FIFO and interrupt control.
// =====================================================================
module sfic_irq_sva
  import sfic_pkg::*;
(
  // Clock, reset and register bus
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              regRead,
  input wire logic              regWrite,
  input wire logic [2:0]        regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic              divisorAccessBit,
  input wire logic [DATA_W-1:0] regRdata,
  // Streams and flags
  input wire logic              rxCharValid,
  input wire logic              rxDataReadyFlag,
  input wire logic              txCharValid,
  input wire logic              txCharTake,
  input wire logic              channelAIrqOut
);
  logic [3:0] enMask;
  logic       fifoOn;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadow copies of the enable mask and FIFO enable, kept from host writes.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      enMask <= IER_RESET;
      fifoOn <= 1'b0;
    end else if (regWrite && regAddr == ADDR_IER && !divisorAccessBit) begin
      enMask <= regWdata[3:0];
    end else if (regWrite && regAddr == ADDR_FIFO) begin
      fifoOn <= regWdata[FCR_EN];
    end
  end
  // Checks of reads, flags and the transmit handshake.
  a_ready_after_push: assert property (
    $rose(rxDataReadyFlag) |-> $past(rxCharValid, 2))
    else $error("data ready rose without a push two cycles earlier");
  a_irq_all_masked: assert property ((enMask == 4'h0) [*3] |-> !channelAIrqOut)
    else $error("interrupt output high with all sources disabled");
  a_ident_top_bits: assert property (
    regRead && regAddr == ADDR_FIFO |=> regRdata[7:4] == {{2{$past(fifoOn)}}, 2'h0})
    else $error("ident upper bits wrong");
  a_ident_bit3_off: assert property (
    regRead && regAddr == ADDR_FIFO && !fifoOn |=> !regRdata[3])
    else $error("ident bit 3 set outside FIFO mode");
  a_mask_read_back: assert property (
    regRead && regAddr == ADDR_IER && !divisorAccessBit |=> regRdata == {4'h0, enMask})
    else $error("enable mask read back wrong");
  a_unmapped_zero: assert property (regRead && regAddr inside {3'h3, 3'h4, 3'h7} |=> regRdata == 8'h00)
    else $error("unmapped address read not zero");
  a_rdata_holds: assert property (!regRead |=> $stable(regRdata))
    else $error("read data changed without a read");
  a_tx_valid_drop: assert property (txCharValid && txCharTake |=> !txCharValid)
    else $error("transmit head still valid after a take");
  // Main scenarios reached.
  c_timeout_seen: cover property (regRead && regAddr == ADDR_FIFO ##1 regRdata[3:0] == IIR_TMO);
  c_tx_taken: cover property (txCharValid && txCharTake);
  c_irq_rise: cover property ($rose(channelAIrqOut));
endmodule // sfic_irq_sva

bind sfic_serial_fifo_irq sfic_irq_sva sfic_irq_sva_i (.clk_sys(clk_sys), .reset_n(reset_n),
  .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
  .divisorAccessBit(divisorAccessBit), .regRdata(regRdata), .rxCharValid(rxCharValid),
  .rxDataReadyFlag(rxDataReadyFlag), .txCharValid(txCharValid), .txCharTake(txCharTake),
  .channelAIrqOut(channelAIrqOut));

// file: sfic_line_model.sv
`timescale 1ns/1ps
// =====================================================================
// Serial side: free-running baud clock and a transmit shifter.
// =====================================================================
module sfic_line_model (
  // Clock and pace
  input  wire logic clk_sys,
  input  wire logic slow,
  // Transmit side
  input  wire logic txCharValid,
  output logic      txCharTake,
  output int        nTaken,
  // Timing
  output logic      rxBaudClk
);
  logic [2:0] div   = 3'h0;
  int         taken = 0;
  // Baud clock at one eighth of the system rate; words taken are counted.
  always @(posedge clk_sys) begin
    div <= div + 3'h1;
    if (txCharValid && txCharTake) begin
      taken <= taken + 1;
    end
  end
  // The count leaves through one continuous driver.
  assign nTaken = taken;
  // A slow shifter accepts only once in eight cycles.
  assign rxBaudClk  = div[2];
  assign txCharTake = txCharValid && (!slow || div == 3'h0);
endmodule // sfic_line_model

// file: test_sfic_serial_fifo_irq.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench of the serial FIFO and interrupt control.
// =====================================================================
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module test_sfic_serial_fifo_irq;
  import sfic_pkg::*;
  logic       clk_sys = 0, reset_n = 0, regRead = 0, regWrite = 0, divisorAccessBit = 0;
  logic       rxCharValid = 0, lineStatusEvent = 0, modemStatusEvent = 0, slow = 0;
  logic       rxCharReady, txCharValid, txCharTake, rxBaudClk, rxDataReadyFlag;
  logic       txHoldingEmpty, rxDmaRequest, txDmaRequest, channelAIrqOut;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, rxCharData = 8'h00, regRdata, txCharData, rdv;
  int         n_mismatch = 0, n_checks = 0, nTaken;
  logic [4:0] lv [4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, TRIG_LVL3};
  // Rows: write address, write data, read address, expected read.
  logic [31:0] rows [4] = '{32'h01ff010f, 32'h01000100, 32'h020102c1, 32'h02000201};
  always #12.5 clk_sys = ~clk_sys;
  sfic_serial_fifo_irq sfic_serial_fifo_irq_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .divisorAccessBit(divisorAccessBit), .regRdata(regRdata), .rxCharValid(rxCharValid),
    .rxCharData(rxCharData), .rxCharReady(rxCharReady), .txCharValid(txCharValid),
    .txCharData(txCharData), .txCharTake(txCharTake), .rxBaudClk(rxBaudClk),
    .charBitTimes(4'ha), .lineStatusEvent(lineStatusEvent), .modemStatusEvent(modemStatusEvent),
    .lineStatusWord(8'h60), .modemStatusWord(8'h0f), .rxDataReadyFlag(rxDataReadyFlag),
    .txHoldingEmpty(txHoldingEmpty), .rxDmaRequest(rxDmaRequest), .txDmaRequest(txDmaRequest),
    .channelAIrqOut(channelAIrqOut));
  sfic_line_model sfic_line_model_i (.clk_sys(clk_sys), .slow(slow), .txCharValid(txCharValid),
    .txCharTake(txCharTake), .nTaken(nTaken), .rxBaudClk(rxBaudClk));
  // One register access; read data is taken at the edge that accepts it.
  task acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys); #2;
    regWrite = wr; regRead = !wr; regAddr = a; regWdata = d;
    @(posedge clk_sys); #2;
    regWrite = 0; regRead = 0; rdv = regRdata;
  endtask
  task ck(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(rdv, e)
  endtask
  task push(input logic [7:0] d);
    @(posedge clk_sys); #2;
    rxCharValid = 1; rxCharData = d;
    @(posedge clk_sys); #2;
    rxCharValid = 0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 14000 cycles.
  initial begin
    #750000;
    n_mismatch++;
    test_done;
  end
  // Main sequence.
  initial begin
    idle(16); #2 reset_n = 1;
    `CHK(txHoldingEmpty, 1'b1)
    ck(ADDR_FIFO, 8'h01);
    foreach (rows[i]) begin
      acc(1'b1, rows[i][26:24], rows[i][23:16]);
      ck(rows[i][10:8], rows[i][7:0]);
    end
    ck(3'h7, 8'h00);
    acc(1'b1, ADDR_IER, 8'h01);
    divisorAccessBit = 1;
    acc(1'b1, ADDR_IER, 8'h0f); ck(ADDR_IER, 8'h00);
    divisorAccessBit = 0;
    ck(ADDR_IER, 8'h01);
    for (int t = 0; t < 4; t++) begin
      acc(1'b1, ADDR_FIFO, {t[1:0], 6'h07});
      for (int j = 1; j < lv[t]; j++) push(8'(j));
      idle(3); ck(ADDR_FIFO, 8'hc1);
      push(8'h00); idle(3); ck(ADDR_FIFO, 8'hc4);
    end
    ck(ADDR_DATA, 8'h01); idle(1); ck(ADDR_FIFO, 8'hc1);
    idle(4400); ck(ADDR_FIFO, 8'hc1);
    idle(1000); ck(ADDR_FIFO, 8'hcc);
    ck(ADDR_DATA, 8'h02); idle(1); ck(ADDR_FIFO, 8'hc1);
    acc(1'b1, ADDR_IER, 8'h00); idle(5600); ck(ADDR_FIFO, 8'hc1);
    `CHK(channelAIrqOut, 1'b0)
    `CHK(rxDataReadyFlag, 1'b1)
    acc(1'b1, ADDR_FIFO, 8'h00); idle(3); `CHK(rxDataReadyFlag, 1'b0)
    push(8'h33); idle(2); `CHK(rxCharReady, 1'b0)
    acc(1'b1, ADDR_FIFO, 8'h01); acc(1'b1, ADDR_IER, 8'h02); idle(2);
    `CHK(rxDataReadyFlag, 1'b0)
    ck(ADDR_FIFO, 8'hc2);
    ck(ADDR_FIFO, 8'hc1);
    slow = 1;
    for (int j = 0; j < 3; j++) acc(1'b1, ADDR_DATA, 8'h55);
    `CHK(txCharData, 8'h55)
    idle(1600); ck(ADDR_FIFO, 8'hc2);
    `CHK(nTaken, 3)
    // A lone byte never fills two places, so the empty indication waits a character.
    acc(1'b1, ADDR_DATA, 8'h66); idle(600);
    `CHK(txHoldingEmpty, 1'b0)
    `CHK(txDmaRequest, 1'b0)
    idle(700); ck(ADDR_FIFO, 8'hc2);
    acc(1'b1, ADDR_FIFO, 8'hc9); push(8'h11); idle(3);
    `CHK(rxDmaRequest, 1'b0)
    `CHK(txDmaRequest, 1'b1)
    acc(1'b1, ADDR_FIFO, 8'h07); acc(1'b1, ADDR_IER, 8'h0d);
    @(posedge clk_sys); #2 lineStatusEvent = 1; modemStatusEvent = 1;
    @(posedge clk_sys); #2 lineStatusEvent = 0; modemStatusEvent = 0;
    push(8'h22); idle(3); ck(ADDR_FIFO, 8'hc6);
    acc(1'b0, ADDR_LSR, 8'h00); ck(ADDR_FIFO, 8'hc4);
    ck(ADDR_DATA, 8'h22); idle(2); ck(ADDR_FIFO, 8'hc0);
    acc(1'b0, ADDR_MSR, 8'h00); ck(ADDR_FIFO, 8'hc1);
    // A reset in mid-run must drop the enables and the FIFO mode again.
    @(posedge clk_sys); #2 reset_n = 0;
    idle(2); #2 reset_n = 1;
    ck(ADDR_IER, 8'h00);
    ck(ADDR_FIFO, 8'h01);
    test_done;
  end
endmodule // test_sfic_serial_fifo_irq
